// File: src/mbcl_defs.svh
/*
 * Constants of the multibank command legality tracker: bank count,
 * timing figures in nanoseconds, burst length and buffer depth.
 * Assumes a 100 ns system clock; timing figures are plain defaults.
 */
`ifndef MBCL_DEFS_SVH
`define MBCL_DEFS_SVH

`define MBCL_CLK_PERIOD_NS        100
`define MBCL_NUM_BANKS            4
`define MBCL_PRECHARGE_PERIOD_NS  18
`define MBCL_ROW_TO_COLUMN_NS     18
`define MBCL_ACT_TO_ACT_GAP_NS    10
`define MBCL_MODE_READ_TIME_NS    20
`define MBCL_MODE_WRITE_TIME_NS   50
`define MBCL_POWER_DOWN_EXIT_NS   8
`define MBCL_INIT_TIME_NS         1000
`define MBCL_BURST_CLKS           2
`define MBCL_FIFO_DEPTH           4
`define MBCL_DATA_W               32
`define MBCL_MASK_W               4

`endif

// File: src/mbcl_pkg.sv
/*
 * Types of the multibank command legality tracker: command codes,
 * per-bank states and device-wide states.
 * Assumes nothing of its surroundings.
 */
package mbcl_pkg;

    typedef enum logic [3:0] {
        MBCL_NOP  = 4'h0,
        MBCL_ACT  = 4'h1,
        MBCL_RD   = 4'h2,
        MBCL_WR   = 4'h3,
        MBCL_PRE  = 4'h4,
        MBCL_BST  = 4'h5,
        MBCL_MRR  = 4'h6,
        MBCL_MRW  = 4'h7,
        MBCL_REF  = 4'h8,
        MBCL_SREF = 4'h9
    } mbcl_cmd_t;

    typedef enum logic [3:0] {
        MBCL_B_IDLE    = 4'h0,
        MBCL_B_ACTVING = 4'h1,
        MBCL_B_ACTIVE  = 4'h3,
        MBCL_B_READING = 4'h2,
        MBCL_B_WRITING = 4'h6,
        MBCL_B_RD_AP   = 4'h7,
        MBCL_B_WR_AP   = 4'h5,
        MBCL_B_PRECHG  = 4'h4,
        MBCL_B_MRR_ACT = 4'hC,
        MBCL_B_MRR_IDL = 4'hD
    } mbcl_bank_st_t;

    typedef enum logic [2:0] {
        MBCL_D_PWR_ON    = 3'h0,
        MBCL_D_RESETTING = 3'h1,
        MBCL_D_NORMAL    = 3'h3,
        MBCL_D_MRW       = 3'h2,
        MBCL_D_MRR_RST   = 3'h5
    } mbcl_dev_st_t;

endpackage

// File: src/mbcl_wfifo.sv
/*
 * Write-data buffer: flip-flop FIFO with valid/ready on both sides.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps

module mbcl_wfifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1)) begin
            return '0;
        end
        return p + AW'(1);
    endfunction

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            end
            if (push && !pop) begin
                count_reg <= count_reg + (AW+1)'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - (AW+1)'(1);
            end
        end
    end

endmodule

// File: src/mbcl_top.sv
/*
 * Multibank command legality and per-bank state tracking for a
 * four-bank memory device, plus the masked write-data path.
 * Assumes commands and write data come from controller logic on the
 * same clock, one command per clock, NOP when idle.
 */
`timescale 1ns/1ps
`include "mbcl_defs.svh"

module mbcl_top #(
    parameter int NUM_BANKS = `MBCL_NUM_BANKS,
    parameter int DATA_W    = `MBCL_DATA_W,
    parameter int MASK_W    = `MBCL_MASK_W,
    parameter int FIFO_DEP  = `MBCL_FIFO_DEPTH,
    parameter int BURST_CLK = `MBCL_BURST_CLKS
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    // command bus
    input  wire logic                   cke,
    input  mbcl_pkg::mbcl_cmd_t         cmd,
    input  wire logic [1:0]             cmd_bank,
    input  wire logic                   cmd_all,
    input  wire logic                   cmd_ap,
    input  wire logic                   cmd_reset,
    // write data from controller
    input  wire logic                   wr_valid,
    output logic                        wr_ready,
    input  wire logic [DATA_W-1:0]      wr_data,
    input  wire logic [MASK_W-1:0]      write_mask_input,
    // write data to array
    output logic                        arr_valid,
    input  wire logic                   arr_ready,
    output logic      [DATA_W-1:0]      arr_data,
    output logic      [MASK_W-1:0]      arr_byte_en,
    // status
    output logic      [4*NUM_BANKS-1:0] bank_state,
    output mbcl_pkg::mbcl_dev_st_t      dev_state,
    output logic                        cmd_armed,
    output logic                        burst_active,
    output logic                        cmd_accept,
    output logic                        cmd_illegal,
    output logic                        illegal_seen
);
    import mbcl_pkg::*;

    function automatic logic [7:0] ns_to_cyc(input int ns);
        int c;
        c = (ns + `MBCL_CLK_PERIOD_NS - 1) / `MBCL_CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return c[7:0];
    endfunction

    function automatic logic pre_ok(input mbcl_bank_st_t s);
        return (s == MBCL_B_IDLE) || (s == MBCL_B_ACTIVE) ||
               (s == MBCL_B_READING) || (s == MBCL_B_WRITING);
    endfunction

    function automatic mbcl_bank_st_t burst_end(input mbcl_bank_st_t s);
        if (s == MBCL_B_RD_AP || s == MBCL_B_WR_AP) begin
            return MBCL_B_PRECHG;
        end
        return MBCL_B_ACTIVE;
    endfunction

    localparam logic [7:0] PRE_CYC  = ns_to_cyc(`MBCL_PRECHARGE_PERIOD_NS);
    localparam logic [7:0] RCD_CYC  = ns_to_cyc(`MBCL_ROW_TO_COLUMN_NS);
    localparam logic [7:0] RRD_CYC  = ns_to_cyc(`MBCL_ACT_TO_ACT_GAP_NS);
    localparam logic [7:0] MRR_CYC  = ns_to_cyc(`MBCL_MODE_READ_TIME_NS);
    localparam logic [7:0] MRW_CYC  = ns_to_cyc(`MBCL_MODE_WRITE_TIME_NS);
    localparam logic [7:0] PDX_CYC  = ns_to_cyc(`MBCL_POWER_DOWN_EXIT_NS);
    localparam logic [7:0] INIT_CYC = ns_to_cyc(`MBCL_INIT_TIME_NS);
    localparam logic [7:0] BST_CYC  = 8'(BURST_CLK);

    mbcl_bank_st_t bank_st_reg  [NUM_BANKS];
    logic [7:0]    bank_tmr_reg [NUM_BANKS];
    mbcl_dev_st_t  dev_st_reg;
    logic [7:0]    dev_tmr_reg;
    logic          cke_prev_reg;
    logic [7:0]    exit_cnt_reg;
    logic [7:0]    rrd_cnt_reg;
    logic [7:0]    burst_cnt_reg;
    logic [1:0]    burst_bank_reg;
    logic          burst_wr_reg;
    logic          cmd_accept_reg;
    logic          cmd_illegal_reg;
    logic          illegal_seen_reg;

    mbcl_bank_st_t tgt;
    logic          legal;
    logic          armed;
    logic          all_idle;
    logic          all_pre_ok;
    logic          mrr_any;
    logic          base_ok;
    logic          burst_on;
    logic          burst_done;
    logic          take;

    ////////////////////////////////////////////////////////////////////
    // clock-enable qualification

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cke_prev_reg <= 1'b0;
            exit_cnt_reg <= 8'h00;
        end else begin
            cke_prev_reg <= cke;
            if (!cke) begin
                exit_cnt_reg <= 8'h00;
            end else if (exit_cnt_reg != PDX_CYC) begin
                exit_cnt_reg <= exit_cnt_reg + 8'h01;
            end
        end
    end

    assign armed = cke && cke_prev_reg && (exit_cnt_reg == PDX_CYC);

    ////////////////////////////////////////////////////////////////////
    // legality decode

    assign burst_on   = (burst_cnt_reg != 8'h00);
    assign burst_done = (burst_cnt_reg == 8'h01);

    always_comb begin
        all_idle   = 1'b1;
        all_pre_ok = 1'b1;
        mrr_any    = 1'b0;
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (bank_st_reg[b] != MBCL_B_IDLE) begin
                all_idle = 1'b0;
            end
            if (!pre_ok(bank_st_reg[b])) begin
                all_pre_ok = 1'b0;
            end
            if (bank_st_reg[b] == MBCL_B_MRR_ACT || bank_st_reg[b] == MBCL_B_MRR_IDL) begin
                mrr_any = 1'b1;
            end
        end
    end

    assign tgt     = bank_st_reg[cmd_bank];
    assign base_ok = armed && (dev_st_reg == MBCL_D_NORMAL) && !mrr_any;

    always_comb begin
        legal = 1'b0;
        unique case (cmd)
            MBCL_NOP: legal = 1'b1;
            MBCL_ACT: legal = base_ok && (tgt == MBCL_B_IDLE)
                              && (rrd_cnt_reg == 8'h00);
            MBCL_RD: legal = base_ok && (tgt == MBCL_B_ACTIVE || tgt == MBCL_B_READING ||
                             tgt == MBCL_B_WRITING)
                             && !(burst_on && burst_wr_reg);
            MBCL_WR: legal = base_ok && (tgt == MBCL_B_ACTIVE || tgt == MBCL_B_READING ||
                             tgt == MBCL_B_WRITING)
                             && !(burst_on && !burst_wr_reg);
            MBCL_PRE: legal = base_ok && (cmd_all ? all_pre_ok : pre_ok(tgt));
            MBCL_BST: legal = base_ok && burst_on && (cmd_bank == burst_bank_reg)
                              && (tgt == MBCL_B_READING || tgt == MBCL_B_WRITING);
            MBCL_MRR: legal = (base_ok && !burst_on && (tgt == MBCL_B_IDLE ||
                              tgt == MBCL_B_ACTVING || tgt == MBCL_B_ACTIVE ||
                              tgt == MBCL_B_PRECHG))
                              || (armed && dev_st_reg == MBCL_D_RESETTING);
            MBCL_MRW: legal = (base_ok && all_idle && !burst_on)
                              || (armed && cmd_reset && dev_st_reg == MBCL_D_PWR_ON);
            MBCL_REF,
            MBCL_SREF: legal = base_ok && all_idle && !burst_on;
            default: legal = 1'b0;
        endcase
    end

    assign take = legal && (cmd != MBCL_NOP);

    ////////////////////////////////////////////////////////////////////
    // per-bank state

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                bank_st_reg[b]  <= MBCL_B_IDLE;
                bank_tmr_reg[b] <= 8'h00;
            end
        end else begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                if (bank_tmr_reg[b] != 8'h00) begin
                    bank_tmr_reg[b] <= bank_tmr_reg[b] - 8'h01;
                end
                if (take && (cmd_bank == 2'(b) || (cmd == MBCL_PRE && cmd_all))) begin
                    unique case (cmd)
                        MBCL_ACT: begin
                            bank_st_reg[b]  <= MBCL_B_ACTVING;
                            bank_tmr_reg[b] <= RCD_CYC - 8'h01;
                        end
                        MBCL_RD: bank_st_reg[b] <= cmd_ap ? MBCL_B_RD_AP
                                                          : MBCL_B_READING;
                        MBCL_WR: bank_st_reg[b] <= cmd_ap ? MBCL_B_WR_AP
                                                          : MBCL_B_WRITING;
                        MBCL_PRE: begin
                            bank_st_reg[b]  <= MBCL_B_PRECHG;
                            bank_tmr_reg[b] <= PRE_CYC - 8'h01;
                        end
                        MBCL_BST: bank_st_reg[b] <= MBCL_B_ACTIVE;
                        MBCL_MRR: begin
                            if (dev_st_reg == MBCL_D_NORMAL) begin
                                bank_st_reg[b]  <= (tgt == MBCL_B_IDLE) ? MBCL_B_MRR_IDL
                                                                        : MBCL_B_MRR_ACT;
                                bank_tmr_reg[b] <= MRR_CYC - 8'h01;
                            end
                        end
                        default: ;
                    endcase
                end else if (take && (cmd == MBCL_RD || cmd == MBCL_WR) && burst_on
                             && burst_bank_reg == 2'(b)) begin
                    bank_st_reg[b] <= burst_end(bank_st_reg[b]);
                    if (burst_end(bank_st_reg[b]) == MBCL_B_PRECHG) begin
                        bank_tmr_reg[b] <= PRE_CYC - 8'h01;
                    end
                end else begin
                    unique case (bank_st_reg[b])
                        MBCL_B_ACTVING: if (bank_tmr_reg[b] == 8'h00) begin
                            bank_st_reg[b] <= MBCL_B_ACTIVE;
                        end
                        MBCL_B_PRECHG: if (bank_tmr_reg[b] == 8'h00) begin
                            bank_st_reg[b] <= MBCL_B_IDLE;
                        end
                        MBCL_B_MRR_ACT: if (bank_tmr_reg[b] == 8'h00) begin
                            bank_st_reg[b] <= MBCL_B_ACTIVE;
                        end
                        MBCL_B_MRR_IDL: if (bank_tmr_reg[b] == 8'h00) begin
                            bank_st_reg[b] <= MBCL_B_IDLE;
                        end
                        MBCL_B_READING, MBCL_B_WRITING, MBCL_B_RD_AP, MBCL_B_WR_AP: begin
                            if (burst_done && burst_bank_reg == 2'(b)) begin
                                bank_st_reg[b] <= burst_end(bank_st_reg[b]);
                                bank_tmr_reg[b] <= PRE_CYC - 8'h01;
                            end
                        end
                        MBCL_B_IDLE, MBCL_B_ACTIVE: ;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // burst and activate spacing

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            burst_cnt_reg  <= 8'h00;
            burst_bank_reg <= 2'h0;
            burst_wr_reg   <= 1'b0;
        end else if (take && (cmd == MBCL_RD || cmd == MBCL_WR)) begin
            burst_cnt_reg  <= BST_CYC;
            burst_bank_reg <= cmd_bank;
            burst_wr_reg   <= (cmd == MBCL_WR);
        end else if (take && cmd == MBCL_BST) begin
            burst_cnt_reg <= 8'h00;
        end else if (burst_on) begin
            burst_cnt_reg <= burst_cnt_reg - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rrd_cnt_reg <= 8'h00;
        end else if (take && cmd == MBCL_ACT) begin
            rrd_cnt_reg <= RRD_CYC - 8'h01;
        end else if (rrd_cnt_reg != 8'h00) begin
            rrd_cnt_reg <= rrd_cnt_reg - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // device-wide state

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dev_st_reg  <= MBCL_D_PWR_ON;
            dev_tmr_reg <= 8'h00;
        end else begin
            if (dev_tmr_reg != 8'h00) begin
                dev_tmr_reg <= dev_tmr_reg - 8'h01;
            end
            unique case (dev_st_reg)
                MBCL_D_PWR_ON, MBCL_D_NORMAL: begin
                    if (take && cmd == MBCL_MRW) begin
                        dev_st_reg  <= cmd_reset ? MBCL_D_RESETTING : MBCL_D_MRW;
                        dev_tmr_reg <= cmd_reset ? INIT_CYC - 8'h01 : MRW_CYC - 8'h01;
                    end
                end
                MBCL_D_RESETTING: begin
                    if (take && cmd == MBCL_MRR) begin
                        dev_st_reg  <= MBCL_D_MRR_RST;
                        dev_tmr_reg <= MRR_CYC - 8'h01;
                    end else if (dev_tmr_reg == 8'h00) begin
                        dev_st_reg <= MBCL_D_NORMAL;
                    end
                end
                MBCL_D_MRW, MBCL_D_MRR_RST: begin
                    if (dev_tmr_reg == 8'h00) begin
                        dev_st_reg <= MBCL_D_NORMAL;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command verdicts

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_accept_reg   <= 1'b0;
            cmd_illegal_reg  <= 1'b0;
            illegal_seen_reg <= 1'b0;
        end else begin
            cmd_accept_reg  <= take;
            cmd_illegal_reg <= !legal;
            if (!legal) begin
                illegal_seen_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // masked write-data path

    logic [DATA_W+MASK_W-1:0] fifo_out;

    mbcl_wfifo #(
        .WIDTH (DATA_W + MASK_W),
        .DEPTH (FIFO_DEP)
    ) u_wfifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   ({write_mask_input, wr_data}),
        .out_valid (arr_valid),
        .out_ready (arr_ready),
        .out_data  (fifo_out)
    );

    assign arr_data    = fifo_out[DATA_W-1:0];
    assign arr_byte_en = ~fifo_out[DATA_W+MASK_W-1:DATA_W];

    ////////////////////////////////////////////////////////////////////
    // status outputs

    always_comb begin
        bank_state = '0;
        for (int b = 0; b < NUM_BANKS; b++) begin
            bank_state[4*b +: 4] = bank_st_reg[b];
        end
    end

    assign dev_state    = dev_st_reg;
    assign cmd_armed    = armed;
    assign burst_active = burst_on;
    assign cmd_accept   = cmd_accept_reg;
    assign cmd_illegal  = cmd_illegal_reg;
    assign illegal_seen = illegal_seen_reg;

endmodule

// File: verif/mbcl_top_monitor.sv
/*
 * Checker of mbcl_top ports.
 * Assumes the bind below.
 */
`timescale 1ns/1ps

module mbcl_top_monitor #(
    parameter int NUM_BANKS = 4,
    parameter int DATA_W    = 32,
    parameter int MASK_W    = 4
) (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   arst_n,
    // command bus
    input wire logic                   cke,
    input mbcl_pkg::mbcl_cmd_t         cmd,
    input wire logic [1:0]             cmd_bank,
    input wire logic                   cmd_reset,
    // buffer drain
    input wire logic                   arr_valid,
    input wire logic                   arr_ready,
    input wire logic [DATA_W-1:0]      arr_data,
    input wire logic [MASK_W-1:0]      arr_byte_en,
    // status
    input wire logic [4*NUM_BANKS-1:0] bank_state,
    input wire logic                   cmd_armed,
    input wire logic                   burst_active,
    input wire logic                   cmd_accept,
    input wire logic                   cmd_illegal,
    input wire logic                   illegal_seen
);
    import mbcl_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_act_seq;
        logic [1:0] b;
        (cmd == MBCL_ACT, b = cmd_bank) ##1 cmd_accept
            |-> bank_state[b*4+:4] == 4'h1 ##1 bank_state[b*4+:4] == 4'h3;
    endproperty

////////////////////////////////////////////////////////////////////////
    AST_ANSWER: assert property (cmd != MBCL_NOP |=> cmd_accept != cmd_illegal)
        else $error("no single answer");
    AST_NOP_QUIET: assert property (cmd == MBCL_NOP |=> !cmd_accept && !cmd_illegal)
        else $error("stray answer");
    AST_STICKY: assert property (cmd_illegal |-> ##[0:1] illegal_seen ##1 illegal_seen)
        else $error("illegal flag lost");
    AST_CKE: assert property (!cke |-> !cmd_armed)
        else $error("armed, cke low");
    AST_NOT_ARMED: assert property (!cmd_armed && cmd != MBCL_NOP |=> cmd_illegal)
        else $error("taken unarmed");
    AST_BST_NO_BURST: assert property (cmd == MBCL_BST && !burst_active |=> cmd_illegal)
        else $error("lone burst stop taken");
    AST_MRW_BUSY: assert property (cmd == MBCL_MRW && !cmd_reset && bank_state != '0
        |=> cmd_illegal) else $error("mode write taken");
    AST_ACT_BUSY: assert property (cmd == MBCL_ACT && bank_state[cmd_bank*4+:4] != 4'h0
        |=> cmd_illegal) else $error("busy activate taken");
    AST_ACT_SEQ: assert property (p_act_seq)
        else $error("activate sequence");
    AST_HOLD: assert property (arr_valid && !arr_ready
        |=> arr_valid && $stable(arr_data) && $stable(arr_byte_en))
        else $error("head moved in stall");

    cover property (cmd == MBCL_BST ##1 cmd_accept);
    cover property (cmd_illegal);
    cover property (burst_active);
    cover property (arr_valid && arr_ready);
endmodule

bind mbcl_top mbcl_top_monitor #(.NUM_BANKS(NUM_BANKS), .DATA_W(DATA_W), .MASK_W(MASK_W))
    i_mon (.clk, .arst_n, .cke, .cmd, .cmd_bank, .cmd_reset, .arr_valid, .arr_ready,
    .arr_data, .arr_byte_en, .bank_state, .cmd_armed, .burst_active, .cmd_accept,
    .cmd_illegal, .illegal_seen);

// File: verif/mbcl_ctrl_model.sv
/*
 * Controller model: commands and write beats.
 * Assumes callers enter at a falling edge.
 */
`timescale 1ns/1ps

module mbcl_ctrl_model (
    // clock
    input wire logic           clk,
    // command bus
    output logic               cke,
    output mbcl_pkg::mbcl_cmd_t cmd,
    output logic [1:0]         cmd_bank,
    output logic               cmd_all,
    output logic               cmd_ap,
    output logic               cmd_reset,
    // write data
    output logic               wr_valid,
    input wire logic           wr_ready,
    output logic [31:0]        wr_data,
    output logic [3:0]         write_mask_input
);
    import mbcl_pkg::*;
    initial begin
        cke = 1'b1;
        cmd = MBCL_NOP;
        {cmd_bank, cmd_all, cmd_ap, cmd_reset, wr_valid} = '0;
        wr_data = 32'h0;
        write_mask_input = 4'h0;
    end

    // held across its sampling edge
    task automatic issue(input mbcl_cmd_t c, input logic [1:0] b = 2'h0,
        input logic ap = 1'b0, input logic all = 1'b0, input logic rst = 1'b0);
        cmd = c;
        cmd_bank = b;
        cmd_ap = ap;
        cmd_all = all;
        cmd_reset = rst;
        @(negedge clk);
    endtask

    // beat held until taken
    task automatic push(input logic [31:0] d, input logic [3:0] m);
        wr_valid = 1'b1;
        wr_data = d;
        write_mask_input = m;
        while (wr_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
    endtask
endmodule

// File: verif/tb_multibank_command_legality.sv
/*
 * Testbench of mbcl_top.
 * Assumes the controller model.
 */
`timescale 1ns/1ps

module tb_multibank_command_legality;
    import mbcl_pkg::*;
    logic         clk, arst_n, arr_ready, wr_ready, arr_valid, cke, cmd_all, cmd_ap;
    logic         cmd_reset, wr_valid, cmd_accept, cmd_illegal, illegal_seen;
    logic         cmd_armed, burst_active;
    logic [1:0]   cmd_bank;
    logic [3:0]   write_mask_input, arr_byte_en;
    logic [15:0]  bank_state;
    logic [31:0]  wr_data, arr_data;
    mbcl_cmd_t    cmd;
    mbcl_dev_st_t dev_state;
    int           errors = 0;
    int           comparisons = 0;

    mbcl_top i_dut (.clk, .arst_n, .cke, .cmd, .cmd_bank, .cmd_all, .cmd_ap, .cmd_reset,
        .wr_valid, .wr_ready, .wr_data, .write_mask_input, .arr_valid, .arr_ready,
        .arr_data, .arr_byte_en, .bank_state, .dev_state, .cmd_armed, .burst_active,
        .cmd_accept, .cmd_illegal, .illegal_seen);
    mbcl_ctrl_model i_ctrl (.clk, .cke, .cmd, .cmd_bank, .cmd_all, .cmd_ap, .cmd_reset,
        .wr_valid, .wr_ready, .wr_data, .write_mask_input);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic logic [3:0] bs(input int b);
        return bank_state[4*b+:4];
    endfunction

    task automatic complete_run;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

////////////////////////////////////////////////////////////////////////
    task automatic go(input mbcl_cmd_t k, input logic [1:0] b = 2'h0);
        i_ctrl.issue(k, b);
    endtask

    task automatic t_init;
        go(MBCL_ACT);
        chk("act_pwr_on", 1, cmd_illegal);
        i_ctrl.issue(MBCL_MRW, 2'h0, 1'b0, 1'b0, 1'b1);
        chk("dev_resetting", MBCL_D_RESETTING, dev_state);
        chk("reset_accept", 1, cmd_accept);
        go(MBCL_MRR);
        chk("dev_mrr_reset", MBCL_D_MRR_RST, dev_state);
        for (int i = 0; i < 30 && dev_state !== MBCL_D_NORMAL; i++) go(MBCL_NOP);
        chk("dev_normal", MBCL_D_NORMAL, dev_state);
        chk("banks_idle", 0, bank_state);
    endtask

    task automatic t_bank;
        go(MBCL_ACT);
        chk("b0_activating", 4'h1, bs(0));
        go(MBCL_NOP);
        chk("b0_active", 4'h3, bs(0));
        go(MBCL_ACT, 2'h1);
        chk("act_other", 1, cmd_accept);
        go(MBCL_RD);
        go(MBCL_BST, 2'h1);
        chk("bst_other_bank", 1, cmd_illegal);
        chk("rd_burst", 1, burst_active);
        chk("b0_reading", 4'h2, bs(0));
        go(MBCL_RD, 2'h1);
        go(MBCL_BST, 2'h1);
        chk("bst_accept", 1, cmd_accept);
        chk("bst_to_active", 4'h3, bs(1));
        i_ctrl.issue(MBCL_RD, 2'h0, 1'b1);
        chk("rd_ap_state", 4'h7, bs(0));
        go(MBCL_WR, 2'h1);
        chk("wr_in_rd_burst", 1, cmd_illegal);
        go(MBCL_PRE);
        chk("pre_busy_bank", 1, cmd_illegal);
        go(MBCL_NOP);
        chk("ap_idle", 4'h0, bs(0));
    endtask

    task automatic t_mrr;
        go(MBCL_MRR, 2'h2);
        chk("mrr_idle_kind", 4'hD, bs(2));
        go(MBCL_ACT, 2'h2);
        chk("cmd_in_mrr", 1, cmd_illegal);
        chk("mrr_idle_end", 4'h0, bs(2));
        go(MBCL_MRR, 2'h1);
        chk("mrr_act_kind", 4'hC, bs(1));
        go(MBCL_NOP);
        chk("mrr_act_end", 4'h3, bs(1));
    endtask

    task automatic t_allidle;
        go(MBCL_BST, 2'h1);
        chk("bst_no_burst", 1, cmd_illegal);
        go(MBCL_MRW);
        chk("mrw_not_idle", 1, cmd_illegal);
        i_ctrl.issue(MBCL_PRE, 2'h0, 1'b0, 1'b1);
        chk("pre_all", 1, cmd_accept);
        go(MBCL_NOP);
        chk("all_idle", 0, bank_state);
        go(MBCL_REF);
        chk("ref_idle", 1, cmd_accept);
        go(MBCL_MRW);
        chk("dev_mrw", MBCL_D_MRW, dev_state);
        go(MBCL_NOP);
        chk("mrw_end", MBCL_D_NORMAL, dev_state);
    endtask

    task automatic t_cke;
        i_ctrl.cke = 1'b0;
        go(MBCL_ACT);
        chk("cke_low", 1, cmd_illegal);
        i_ctrl.cke = 1'b1;
        repeat (4) go(MBCL_NOP);
        chk("rearmed", 1, cmd_armed);
    endtask

    task automatic t_fifo;
        logic [3:0] m;
        for (int i = 0; i < 4; i++) i_ctrl.push(32'h11111111 * i, 4'h5 * i[3:0]);
        i_ctrl.wr_valid = 1'b0;
        chk("fifo_full", 0, wr_ready);
        arr_ready = 1'b1;
        for (int i = 0; i < 4; i++) begin
            m = ~(4'h5 * i[3:0]);
            chk("arr_data", 32'h11111111 * i, arr_data);
            chk("byte_en", m, arr_byte_en);
            @(negedge clk);
        end
        chk("fifo_empty", 0, arr_valid);
    endtask

////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        arr_ready = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (2) go(MBCL_NOP);
        t_init;
        t_bank;
        t_mrr;
        t_allidle;
        t_cke;
        t_fifo;
        chk("illegal_seen", 1, illegal_seen);
        complete_run;
    end

    initial begin
        #200000;
        errors++;
        complete_run;
    end
endmodule
